// ==== rtl/srp_top.sv ====
// service request status logic for modem and parallel request types
`timescale 1ns/10ps
`default_nettype none
module srp_top (
  input  wire logic        clk_i,              // 50 MHz system clock
  input  wire logic        rst_n_i,            // synchronous reset, active low
  // ahb-lite slave
  input  wire logic        hsel_i,             // slave select
  input  wire logic [31:0] haddr_i,            // byte address
  input  wire logic [1:0]  htrans_i,           // transfer type
  input  wire logic        hwrite_i,           // write when high
  input  wire logic [2:0]  hsize_i,            // transfer size
  input  wire logic [31:0] hwdata_i,           // write data
  input  wire logic        hready_i,           // bus ready
  output logic      [31:0] hrdata_o,           // read data
  output logic             hreadyout_o,        // slave ready
  output logic             hresp_o,            // always okay
  // internal processor requests
  input  wire logic        mdm_req_i,          // modem service wanted
  input  wire logic [1:0]  mdm_chan_i,         // channel wanting modem service
  input  wire logic        port_src_i,         // control machine wants service
  input  wire logic        pipe_src_i,         // data pipeline wants service
  // pins
  input  wire logic        service_acknowledge_pin_n_i, // hardware ack, active low
  output logic             service_request_pin_n_o,     // modem request, active low
  output logic             parallel_request_pin_n_o,    // parallel request, active low
  output logic      [1:0]  serviced_channel_o,          // channel selected for service
  output logic             irq_o                        // level interrupt
);
  typedef struct packed {
    logic       mdm_req;       // modem request latch
    logic       mdm_busy;      // modem cycle in progress
    logic       mdm_hold;      // modem fairness hold
    logic [1:0] mdm_chan;      // requesting channel
    logic       par_req;       // parallel request latch
    logic       par_busy;      // parallel cycle in progress
    logic       par_hold;      // parallel fairness hold
    logic [1:0] par_src;       // port, pipeline sources
    logic [7:0] chan_access;   // channel access register
    logic [7:0] ctrl;          // control bits
    logic [3:0] mask;          // interrupt mask
    logic       dph;           // data phase pending
    logic       dwr;           // pending is a write
    logic [7:0] didx;          // pending register index
    logic [31:0] rdata;        // read data register
  } srp_state_t;
  srp_state_t st;
  srp_state_t next_st;
  logic       ack_rise;        // ack pin fell
  logic [3:0] irq_status;      // sticky events
  logic [3:0] irq_event;       // event pulses
  logic [3:0] irq_clear;       // clear strobes
  logic [7:0] mdm_status;      // assembled modem status
  logic [7:0] par_status;      // assembled parallel status
  logic       addr_ok;         // address phase accepted
  logic       wr_now;          // write data present
  logic [7:0] wbyte;           // written byte
  logic       fair_dis;        // fairness disable
  logic       poll;            // poll mode
  // detect assertion of active-low ack
  srp_edge u_ack (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .level_i (~service_acknowledge_pin_n_i),
    .rise_o  (ack_rise)
  );
  // interrupt collector
  srp_irq u_irq (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .event_i  (irq_event),
    .clear_i  (irq_clear),
    .mask_i   (st.mask),
    .status_o (irq_status),
    .irq_o    (irq_o)
  );
  assign fair_dis = st.ctrl[srp_pkg::CTRL_FAIR_DIS];
  assign poll     = st.ctrl[srp_pkg::CTRL_POLL_MODE];
  // status read images
  always_comb begin
    mdm_status = {st.mdm_req, st.mdm_busy, st.mdm_hold, srp_pkg::MDM_CONTEXT, st.mdm_chan};
    par_status = {st.par_req, st.par_src, 5'h00};
  end
  assign addr_ok = hsel_i & hready_i & (htrans_i == srp_pkg::HTRANS_NONSEQ)
                 & (hsize_i == srp_pkg::HSIZE_WORD);
  assign wr_now  = st.dph & st.dwr;
  assign wbyte   = hwdata_i[7:0];
  // main next-state logic
  always_comb begin
    next_st   = st;
    irq_event = 4'h0;
    irq_clear = 4'h0;
    next_st.dph = 1'b0;
    // capture address phase
    if (addr_ok) begin
      next_st.dph  = 1'b1;
      next_st.dwr  = hwrite_i;
      next_st.didx = haddr_i[9:2];
      // read data prepared for the data phase
      unique case (haddr_i[9:2])
        srp_pkg::MDM_STATUS_IDX:  next_st.rdata = {24'h000000, mdm_status};
        srp_pkg::PAR_STATUS_IDX:  next_st.rdata = {24'h000000, par_status};
        srp_pkg::CHAN_ACCESS_IDX: next_st.rdata = {24'h000000, st.chan_access};
        srp_pkg::CTRL_IDX:        next_st.rdata = {24'h000000, st.ctrl};
        srp_pkg::IRQ_STATUS_IDX:  next_st.rdata = {28'h0000000, irq_status};
        srp_pkg::IRQ_MASK_IDX:    next_st.rdata = {28'h0000000, st.mask};
        default:                  next_st.rdata = 32'h00000000;
      endcase
    end
    // hardware acknowledge clears the pending modem or parallel request and sets its hold, else releases both holds
    if (ack_rise) begin
      if (st.mdm_req) begin
        next_st.mdm_req  = 1'b0;
        next_st.mdm_hold = 1'b1;
      end else if (st.par_req) begin
        next_st.par_req  = 1'b0;
        next_st.par_hold = 1'b1;
      end else begin
        next_st.mdm_hold = 1'b0;
        next_st.par_hold = 1'b0;
      end
    end
    // register writes
    if (wr_now) begin
      unique case (st.didx)
        srp_pkg::MDM_STATUS_IDX: begin
          if (!wbyte[srp_pkg::BUSY_BIT] && st.mdm_busy) irq_event[srp_pkg::IRQ_MDM_END] = 1'b1;
          next_st.mdm_busy = st.mdm_busy & wbyte[srp_pkg::BUSY_BIT];
          next_st.mdm_req  = st.mdm_req & wbyte[srp_pkg::REQ_BIT];
        end
        srp_pkg::PAR_STATUS_IDX: begin
          if (!wbyte[srp_pkg::REQ_BIT] && st.par_busy) irq_event[srp_pkg::IRQ_PAR_END] = 1'b1;
          next_st.par_req  = st.par_req & wbyte[srp_pkg::REQ_BIT];
          next_st.par_busy = st.par_busy & wbyte[srp_pkg::REQ_BIT];
        end
        srp_pkg::CHAN_ACCESS_IDX: begin
          next_st.chan_access = wbyte;
        end
        srp_pkg::CTRL_IDX: begin
          if (wbyte[srp_pkg::CTRL_PAR_IEN] != st.ctrl[srp_pkg::CTRL_PAR_IEN]) begin
            next_st.par_req = 1'b0;
          end
          next_st.ctrl = wbyte;
        end
        srp_pkg::EOS_IDX: begin
          if (st.mdm_busy) begin
            next_st.mdm_busy = 1'b0;
            irq_event[srp_pkg::IRQ_MDM_END] = 1'b1;
          end else if (st.par_busy) begin
            next_st.par_busy = 1'b0;
            irq_event[srp_pkg::IRQ_PAR_END] = 1'b1;
          end
        end
        srp_pkg::IRQ_STATUS_IDX: irq_clear = wbyte[3:0];
        srp_pkg::IRQ_MASK_IDX:   next_st.mask = wbyte[3:0];
        default: ;
      endcase
    end
    // raise modem request only when idle
    if (mdm_req_i && !st.mdm_busy && !st.mdm_req && !(st.mdm_hold && !poll)) begin
      next_st.mdm_req  = 1'b1;
      next_st.mdm_busy = 1'b1;
      next_st.mdm_chan = mdm_chan_i;
      irq_event[srp_pkg::IRQ_MDM_REQ] = 1'b1;
    end
    if ((port_src_i || pipe_src_i) && !st.par_busy && !st.par_req
        && !(st.par_hold && !poll)) begin
      next_st.par_req  = 1'b1;
      next_st.par_busy = 1'b1;
      next_st.par_src  = {port_src_i, pipe_src_i};
      irq_event[srp_pkg::IRQ_PAR_REQ] = 1'b1;
    end
    if (fair_dis || poll) begin
      next_st.mdm_hold = 1'b0;
      next_st.par_hold = 1'b0;
    end
  end
  // state register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st      <= '0;
      st.ctrl <= srp_pkg::CTRL_RST;
    end else begin
      st <= next_st;
    end
  end
  assign service_request_pin_n_o  = ~st.mdm_req;
  assign parallel_request_pin_n_o = ~st.par_req;
  assign serviced_channel_o       = st.chan_access[1:0];
  assign hrdata_o    = st.rdata;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  mdm_pin_inv_a: assert property (service_request_pin_n_o == ~mdm_status[7])
    else $error("modem pin not inverse of flag");
  ack_clears_a: assert property ((ack_rise && st.mdm_req) |=> !st.mdm_req)
    else $error("ack did not clear modem request");
  eos_busy_a: assert property (
    (wr_now && st.didx == srp_pkg::EOS_IDX && st.mdm_busy) |=> !st.mdm_busy)
    else $error("end of service did not end busy");
  req_busy_a: assert property ($rose(st.mdm_req) |-> st.mdm_busy)
    else $error("request raised without busy");
  busy_block_a: assert property ((st.mdm_busy && !st.mdm_req) |=> !$rose(st.mdm_req))
    else $error("request raised while busy");
  hold_block_a: assert property (
    (st.mdm_hold && !poll && !ack_rise) |=> !$rose(st.mdm_req))
    else $error("request raised while held");
  par_busy_a: assert property ((st.par_busy && !st.par_req) |=> !$rose(st.par_req))
    else $error("parallel request raised while busy");
  par_hold_a: assert property (
    (st.par_hold && !poll && !ack_rise) |=> !$rose(st.par_req))
    else $error("parallel request raised while held");
  fair_dis_a: assert property (fair_dis |=> (!st.mdm_hold && !st.par_hold))
    else $error("hold flags not forced low");
  poll_hold_a: assert property (poll |=> (!st.mdm_hold && !st.par_hold))
    else $error("hold used in poll mode");
  ctx_fixed_a: assert property (
    (st.dph && !st.dwr && st.didx == srp_pkg::MDM_STATUS_IDX) |-> hrdata_o[4:2] == 3'h2)
    else $error("context bits changed");
  chan_latch_a: assert property (
    $rose(st.mdm_req) |-> st.mdm_chan == $past(mdm_chan_i))
    else $error("requesting channel not latched");
  par_pin_inv_a: assert property (parallel_request_pin_n_o == ~par_status[7])
    else $error("parallel pin not inverse of flag");
  par_ack_a: assert property (
    (ack_rise && !st.mdm_req && st.par_req) |=> !st.par_req)
    else $error("ack did not clear parallel request");
  ien_clr_a: assert property (
    (wr_now && st.didx == srp_pkg::CTRL_IDX && st.par_req
     && wbyte[srp_pkg::CTRL_PAR_IEN] != st.ctrl[srp_pkg::CTRL_PAR_IEN]) |=> !st.par_req)
    else $error("enable toggle did not clear request");
  src_latch_a: assert property (
    $rose(st.par_req) |-> st.par_src == {$past(port_src_i), $past(pipe_src_i)})
    else $error("request sources not latched");
  par_res_a: assert property (
    (st.dph && !st.dwr && st.didx == srp_pkg::PAR_STATUS_IDX) |-> hrdata_o[4:0] == 5'h00)
    else $error("parallel reserved bits nonzero");
  chan_sel_a: assert property (
    (wr_now && st.didx == srp_pkg::CHAN_ACCESS_IDX) |=> serviced_channel_o == $past(wbyte[1:0]))
    else $error("channel select not taken");
  rst_val_a: assert property (
    $rose(rst_n_i) |-> (mdm_status == srp_pkg::MDM_STATUS_RST
                        && par_status == srp_pkg::PAR_STATUS_RST))
    else $error("status not at reset values");

  // cover the main scenarios
  mdm_req_c: cover property ($rose(st.mdm_req) ##[1:20] ack_rise);
  par_req_c: cover property ($rose(st.par_req) && st.par_src == 2'h3);
  eos_c:     cover property ($fell(st.mdm_busy));
  hold_rel_c: cover property (ack_rise && st.mdm_hold && !st.mdm_req && !st.par_req);
  ien_clr_c:  cover property (wr_now && st.didx == srp_pkg::CTRL_IDX && st.par_req);
endmodule
`default_nettype wire

// ==== rtl/srp_pkg.sv ====
// package: register map, field positions, reset values for service request status
package srp_pkg;
  // printed offsets are not multiples of four: they are indices, byte address is 4x
  localparam logic [7:0]  PAR_STATUS_IDX   = 8'h61;
  localparam logic [7:0]  MDM_STATUS_IDX   = 8'h69;
  localparam logic [7:0]  CHAN_ACCESS_IDX  = 8'h68;
  localparam logic [7:0]  CTRL_IDX         = 8'h7A;
  localparam logic [7:0]  IRQ_STATUS_IDX   = 8'h7B;
  localparam logic [7:0]  IRQ_MASK_IDX     = 8'h7C;
  localparam logic [7:0]  EOS_IDX          = 8'h60;
  // field positions
  localparam int          REQ_BIT          = 7;
  localparam int          BUSY_BIT         = 6;
  localparam int          HOLD_BIT         = 5;
  localparam int          PORT_SRC_BIT     = 6;
  localparam int          PIPE_SRC_BIT     = 5;
  localparam int          CTRL_FAIR_DIS    = 0;
  localparam int          CTRL_POLL_MODE   = 1;
  localparam int          CTRL_PAR_IEN     = 4;
  // reset values
  localparam logic [7:0]  MDM_STATUS_RST   = 8'h08;
  localparam logic [7:0]  PAR_STATUS_RST   = 8'h00;
  localparam logic [2:0]  MDM_CONTEXT      = 3'h2;
  localparam logic [7:0]  CTRL_RST         = 8'h00;
  localparam logic [3:0]  IRQ_RST          = 4'h0;
  // interrupt status bit positions
  localparam int          IRQ_MDM_REQ      = 0;
  localparam int          IRQ_PAR_REQ      = 1;
  localparam int          IRQ_MDM_END      = 2;
  localparam int          IRQ_PAR_END      = 3;
  // ahb constants
  localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
  localparam logic [2:0]  HSIZE_WORD       = 3'h2;
endpackage

// ==== rtl/srp_edge.sv ====
// rising edge detector for a synchronous level
`timescale 1ns/10ps
`default_nettype none
module srp_edge (
  input  wire logic clk_i,     // system clock
  input  wire logic rst_n_i,   // synchronous reset, active low
  input  wire logic level_i,   // level to watch
  output logic      rise_o     // one-cycle pulse on a rise
);
  typedef struct packed {
    logic prev;                // level one cycle ago
  } srp_edge_state_t;
  srp_edge_state_t st;
  srp_edge_state_t next_st;
  // next state is just the level
  always_comb begin
    next_st      = st;
    next_st.prev = level_i;
  end
  // register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign rise_o = level_i & ~st.prev;
endmodule
`default_nettype wire

// ==== rtl/srp_irq.sv ====
// sticky event bits, write-one-to-clear, masked onto one level interrupt
`timescale 1ns/10ps
`default_nettype none
module srp_irq (
  input  wire logic       clk_i,       // system clock
  input  wire logic       rst_n_i,     // synchronous reset, active low
  input  wire logic [3:0] event_i,     // one-cycle event pulses
  input  wire logic [3:0] clear_i,     // write-one-to-clear strobes
  input  wire logic [3:0] mask_i,      // enable per bit
  output logic      [3:0] status_o,    // sticky bits
  output logic            irq_o        // level interrupt
);
  typedef struct packed {
    logic [3:0] status;                // sticky event bits
  } srp_irq_state_t;
  srp_irq_state_t st;
  srp_irq_state_t next_st;
  // set wins over clear
  always_comb begin
    next_st        = st;
    next_st.status = (st.status & ~clear_i) | event_i;
  end
  // register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st.status <= srp_pkg::IRQ_RST;
    end else begin
      st <= next_st;
    end
  end
  assign status_o = st.status;
  assign irq_o    = |(st.status & mask_i);
endmodule
`default_nettype wire

// ==== tb/srp_host_ack.sv ====
// host side model: pulses the active-low acknowledge pin after a chosen delay
`timescale 1ns/10ps
`default_nettype none
module srp_host_ack (
  input  wire logic       clk_i,       // system clock
  input  wire logic       rst_n_i,     // synchronous reset, active low
  input  wire logic       auto_i,      // acknowledge pending requests
  input  wire logic       kick_i,      // acknowledge with nothing pending
  input  wire logic [3:0] delay_i,     // extra cycles before the pulse
  input  wire logic       req_pin_n_i, // any request pin low
  output logic            ack_pin_n_o  // acknowledge pin, active low
);
  logic [4:0] cnt;                     // countdown, pulse in last two steps
  // countdown starts only when idle
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt <= 5'h00;
    end else if (cnt != 5'h00) begin
      cnt <= cnt - 5'h01;
    end else if ((auto_i && !req_pin_n_i) || kick_i) begin
      cnt <= 5'({1'b0, delay_i}) + 5'h03;
    end
  end
  assign ack_pin_n_o = !(cnt == 5'h02 || cnt == 5'h01);
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench for the service request status block
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam logic [31:0] A_PAR = 32'(srp_pkg::PAR_STATUS_IDX) << 2;
  localparam logic [31:0] A_MDM = 32'(srp_pkg::MDM_STATUS_IDX) << 2;
  localparam logic [31:0] A_CAR = 32'(srp_pkg::CHAN_ACCESS_IDX) << 2;
  localparam logic [31:0] A_CTL = 32'(srp_pkg::CTRL_IDX) << 2;
  localparam logic [31:0] A_IST = 32'(srp_pkg::IRQ_STATUS_IDX) << 2;
  localparam logic [31:0] A_MSK = 32'(srp_pkg::IRQ_MASK_IDX) << 2;
  localparam logic [31:0] A_EOS = 32'(srp_pkg::EOS_IDX) << 2;
  logic clk_i, rst_n_i, hsel, hwrite, hreadyout, hresp, rd_ph;   // bus and phase
  logic [31:0] haddr, hwdata, hrdata;                            // bus words
  logic [1:0]  htrans, mdm_chan, srv_chan, ch;                   // transfer type, channel numbers
  logic [2:0]  hsize;                                            // transfer size
  logic mdm_req, port_src, pipe_src, ack_n, mreq_n, preq_n, irq; // block pins
  logic auto_ack, kick;                                          // host model controls
  logic [3:0]  dly;                                              // host model delay
  logic [31:0] exp_q[$];                                         // expected read data
  int errors, num_checks;
  srp_top u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
    .mdm_req_i(mdm_req), .mdm_chan_i(mdm_chan), .port_src_i(port_src), .pipe_src_i(pipe_src),
    .service_acknowledge_pin_n_i(ack_n), .service_request_pin_n_o(mreq_n),
    .parallel_request_pin_n_o(preq_n), .serviced_channel_o(srv_chan), .irq_o(irq));
  srp_host_ack u_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .auto_i(auto_ack), .kick_i(kick),
    .delay_i(dly), .req_pin_n_i(mreq_n & preq_n), .ack_pin_n_o(ack_n));
  // clock, 20 ns period
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // one comparison, counted
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // single ahb transfer: address phase, then data phase
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    int n;
    htrans <= srp_pkg::HTRANS_NONSEQ;
    hsize  <= srp_pkg::HSIZE_WORD;
    haddr  <= a;
    hwrite <= w;
    hsel   <= 1'b1;
    n = 0;
    do begin @(posedge clk_i); n++; end while (hreadyout !== 1'b1 && n < 100);
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph  <= !w;
    n = 0;
    do begin @(posedge clk_i); n++; end while (hreadyout !== 1'b1 && n < 100);
    rd_ph <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    bus(a, 1'b0, 32'h0);
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    bus(a, 1'b1, {24'h0, d});
  endtask
  // let the host model acknowledge one pending request
  task automatic ack_once();
    int n;
    auto_ack <= 1'b1;
    n = 0;
    do begin @(posedge clk_i); n++; end while ((mreq_n & preq_n) !== 1'b1 && n < 60);
    auto_ack <= 1'b0;
    tick(3);
  endtask
  // read data watcher, oldest note first
  always @(posedge clk_i) begin
    if (rd_ph && hreadyout === 1'b1) check("hrdata", hrdata, exp_q.pop_front());
  end
  // hang guard
  initial begin
    #400us;
    errors++;
    give_verdict();
  end
  initial begin
    {hsel, hwrite, rd_ph, mdm_req, port_src, pipe_src, auto_ack, kick} = '0;
    {haddr, hwdata, htrans, hsize, mdm_chan} = '0;
    rst_n_i = 1'b0;
    dly = 4'h0;
    void'($urandom(97291));
    ch = 2'($urandom % 4);
    if (ch == 2'h1) ch = 2'h3;
    tick(12);
    rst_n_i <= 1'b1;
    dly <= 4'($urandom % 8);
    tick(1);
    rd(A_MDM, 8'h08);
    rd(A_PAR, 8'h00);
    check("req_pin", {31'h0, mreq_n}, 32'h1);
    check("hresp", {31'h0, hresp}, 32'h0);
    mdm_chan <= ch; mdm_req <= 1'b1;
    wr(A_MSK, 8'h01);
    tick(3);
    check("req_pin", {31'h0, mreq_n}, 32'h0);
    check("irq", {31'h0, irq}, 32'h1);
    rd(A_IST, 8'h01);
    rd(A_MDM, 8'hC8 | ch);
    wr(A_MDM, 8'h48 | ch);
    wr(A_IST, 8'h0F);
    tick(3);
    rd(A_MDM, 8'h48 | ch);
    check("irq", {31'h0, irq}, 32'h0);
    wr(A_EOS, 8'h00);
    tick(3);
    rd(A_MDM, 8'hC8 | ch);
    ack_once();
    rd(A_MDM, 8'h68 | ch);
    wr(A_EOS, 8'h00);
    tick(3);
    rd(A_MDM, 8'h28 | ch);
    kick <= 1'b1;
    tick(1);
    kick <= 1'b0;
    tick(16);
    rd(A_MDM, 8'hC8 | ch);
    ack_once();
    wr(A_EOS, 8'h00);
    wr(A_CTL, 8'h01);
    tick(3);
    rd(A_MDM, 8'hC8 | ch);
    wr(A_CTL, 8'h02);
    ack_once();
    rd(A_MDM, 8'h48 | ch);
    mdm_req <= 1'b0;
    wr(A_MDM, 8'h08);
    wr(A_CTL, 8'h00);
    port_src <= 1'b1; pipe_src <= 1'b1;
    tick(3);
    check("par_pin", {31'h0, preq_n}, 32'h0);
    rd(A_PAR, 8'hE0);
    wr(A_PAR, 8'h80);
    rd(A_PAR, 8'hE0);
    wr(A_CTL, 8'h10);
    tick(3);
    rd(A_PAR, 8'h60);
    check("par_pin", {31'h0, preq_n}, 32'h1);
    wr(A_EOS, 8'h00);
    tick(3);
    ack_once();
    check("par_pin", {31'h0, preq_n}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      if (i != 1) begin
        wr(A_CAR, 8'h08 | 8'(i));
        tick(2);
        check("chan", {30'h0, srv_chan}, 32'(i));
      end
    end
    rd(32'h0000_03FC, 8'h00);
    // mid-run reset with the sources quiet
    port_src <= 1'b0;
    pipe_src <= 1'b0;
    rst_n_i <= 1'b0;
    tick(3);
    rst_n_i <= 1'b1;
    tick(1);
    rd(A_MDM, 8'h08);
    rd(A_PAR, 8'h00);
    check("par_pin", {31'h0, preq_n}, 32'h1);
    give_verdict();
  end
endmodule
`default_nettype wire
